/* File: dv/pba_arbiter_bench.sv */
`timescale 1ns/1ns
`define CHK(n,e,a) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module pba_arbiter_bench;
  logic clk_sys = 0, sys_rst = 1, strap = 1, core_req = 0, bus_idle = 1;
  logic [4:0] en = 5'h1F, hi = 5'h1F, gv, seen;
  logic [3:0] wish = 4'h0, rq, mq, ro, roe, gi, go, goe;
  logic cg;
  logic [31:0] rs = 32'h34ECEA0D;
  int errors = 0, checked = 0, cyc = 0;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // with strap set, every enabled requester that asks is served, plus the parked core; nothing without strap
  function automatic logic [4:0] want(input logic s, input logic [4:0] e,
    input logic [3:0] w, input logic c);
    return s ? ((e & {w, c}) | 5'h01) : 5'h00;
  endfunction
  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic run(input int t);
    logic c;
    rs = xs(rs);
    c = (t < 2 || t == 6) ? 1'b1 : rs[14];
    sys_rst <= 1;
    wish <= 4'h0;
    core_req <= 0;
    strap <= (t != 6);
    en <= (t > 1 && t < 6) ? rs[4:0] : 5'h1F;
    hi <= t == 1 ? 5'h03 : (t > 1 ? rs[9:5] : 5'h1F);
    repeat (16) @(negedge clk_sys);
    sys_rst <= 0;
    wish <= t == 6 ? 4'h0 : (t < 2 ? 4'hF : rs[13:10]);
    core_req <= c;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_sys);
      rs = xs(rs);
      bus_idle <= rs[0] | (i > 150);
    end
    `CHK("served", want(strap, en, wish, c), seen)
    if (t == 6) `CHK("core", 1'b0, core_req)
    $display("test %0d done", t);
  endtask
  initial forever #20 clk_sys = ~clk_sys;
  // requester pin 0 is the bridge's own when it drives it
  assign rq = {mq[3:1], roe[0] ? ro[0] : mq[0]};
  always @(posedge clk_sys) begin
    seen <= sys_rst ? 5'h00 : seen | gv;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  // core drops its request once granted
  always @(negedge clk_sys) if (cg && !sys_rst) core_req <= 0;
  pba_master_model pba_master_model_i (.clk_sys(clk_sys), .wish(wish),
    .gnt_n(go), .gnt_oe(goe), .req0_n(ro[0]), .req_n(mq), .gnt_in_n(gi));
  pba_arbiter pba_arbiter_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .arbiter_enable_strap(strap), .cfg_req_enable(en), .cfg_req_high(hi),
    .core_req(core_req), .bus_idle(bus_idle), .ext_req_n_in(rq),
    .ext_req_n_out(ro), .ext_req_n_oe(roe), .ext_gnt_n_in(gi),
    .ext_gnt_n_out(go), .ext_gnt_n_oe(goe), .core_gnt(cg), .grant_vec(gv));
  initial begin
    for (int t = 0; t < 7; t++) run(t);
    end_sim();
  end
endmodule

/* File: dv/pba_arbiter_properties.sv */
`timescale 1ns/1ns
// port checks of the arbiter
module pba_arbiter_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic arbiter_enable_strap,
  input wire logic [4:0] cfg_req_enable,
  input wire logic core_req,
  input wire logic bus_idle,
  input wire logic [3:0] ext_req_n_in,
  input wire logic [3:0] ext_req_n_oe,
  input wire logic [3:0] ext_gnt_n_out,
  input wire logic [3:0] ext_gnt_n_oe,
  input wire logic core_gnt,
  input wire logic [4:0] grant_vec
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_live;
    !$past(sys_rst) && arbiter_enable_strap;
  endsequence
  sequence s_quiet;
    (bus_idle && &ext_req_n_in && !core_req) [*6];
  endsequence
  property p_one; $onehot0(grant_vec); endproperty
  property p_oe; ext_req_n_oe[3:1] == 3'h0; endproperty
  property p_req0;
    !$past(sys_rst) |-> ext_req_n_oe[0] == !arbiter_enable_strap;
  endproperty
  property p_off;
    !$past(sys_rst) && !arbiter_enable_strap |->
      grant_vec == 5'h00 && ext_gnt_n_oe == 4'h0;
  endproperty
  property p_core; s_live |-> core_gnt == grant_vec[0]; endproperty
  property p_pins;
    s_live |-> ext_gnt_n_out == ~grant_vec[4:1] && ext_gnt_n_oe == 4'hF;
  endproperty
  property p_dis;
    s_live |-> (grant_vec[4:1] & ~cfg_req_enable[4:1]) == 4'h0;
  endproperty
  property p_park0;
    $fell(sys_rst) && arbiter_enable_strap |=> grant_vec == 5'h01;
  endproperty
  property p_park; s_quiet |=> $stable(grant_vec); endproperty
  a_one: assert property (p_one) else $error("two grants");
  a_oe: assert property (p_oe) else $error("req oe set");
  a_req0: assert property (p_req0) else $error("req0 oe");
  a_off: assert property (p_off) else $error("grant off");
  a_core: assert property (p_core) else $error("core gnt");
  a_pins: assert property (p_pins) else $error("gnt pins");
  a_dis: assert property (p_dis) else $error("disabled gnt");
  a_park0: assert property (p_park0) else $error("park core");
  a_park: assert property (p_park) else $error("park moved");
endmodule
bind pba_arbiter pba_arbiter_properties pba_arbiter_properties_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst),
  .arbiter_enable_strap(arbiter_enable_strap),
  .cfg_req_enable(cfg_req_enable), .core_req(core_req),
  .bus_idle(bus_idle), .ext_req_n_in(ext_req_n_in),
  .ext_req_n_oe(ext_req_n_oe), .ext_gnt_n_out(ext_gnt_n_out),
  .ext_gnt_n_oe(ext_gnt_n_oe), .core_gnt(core_gnt),
  .grant_vec(grant_vec));

/* File: dv/pba_master_model.sv */
`timescale 1ns/1ns
// outside masters and outside arbiter
module pba_master_model (
  input wire logic clk_sys,
  input wire logic [3:0] wish,
  input wire logic [3:0] gnt_n,
  input wire logic [3:0] gnt_oe,
  input wire logic req0_n,
  output logic [3:0] req_n,
  output logic [3:0] gnt_in_n
);
  logic [3:0] done_q = 4'h0;
  logic ext_gnt_q = 1'b1;
  // hold request until granted
  always @(negedge clk_sys) begin
    done_q <= wish & (done_q | (~gnt_n & gnt_oe));
    ext_gnt_q <= req0_n;
  end
  assign req_n = ~(wish & ~done_q);
  // pins 3..1 pulled up when undriven; pin 0 from the outside arbiter
  assign gnt_in_n = gnt_oe[0] ? gnt_n : {3'h7, ext_gnt_q};
endmodule

/* File: rtl/pba_arbiter.sv */
`timescale 1ns/1ns
// secondary bus arbiter; index 0 is the internal core, 1..4 external
module pba_arbiter (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic arbiter_enable_strap,
  input wire logic [4:0] cfg_req_enable,
  input wire logic [4:0] cfg_req_high,
  input wire logic core_req,
  input wire logic bus_idle,
  input wire logic [3:0] ext_req_n_in,
  output logic [3:0] ext_req_n_out,
  output logic [3:0] ext_req_n_oe,
  input wire logic [3:0] ext_gnt_n_in,
  output logic [3:0] ext_gnt_n_out,
  output logic [3:0] ext_gnt_n_oe,
  output logic core_gnt,
  output logic [4:0] grant_vec
);
  logic [3:0] req_n_s;
  logic gnt0_n_s;
  logic strap_q;
  logic strap_cap_q;
  logic [4:0] enable_q;
  logic [4:0] high_q;
  pba_pkg::pba_state_type state_q;
  pba_pkg::pba_state_type state_d;
  logic [4:0] hsnap_q;
  logic [4:0] hsnap_d;
  logic [4:0] lsnap_q;
  logic [4:0] lsnap_d;
  logic [4:0] hlast_q;
  logic [4:0] hlast_d;
  logic [4:0] llast_q;
  logic [4:0] llast_d;
  logic low_slot_q;
  logic low_slot_d;
  logic [4:0] gnt_q;
  logic [4:0] gnt_d;
  logic [4:0] hpick;
  logic [4:0] lpick;

  // pins from the bus pass the three-stage filter
  pba_sync #(.W(4)) u_req_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d_in(ext_req_n_in),
    .rst_val(4'hF),
    .q_out(req_n_s)
  );
  pba_sync #(.W(1)) u_gnt_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d_in(ext_gnt_n_in[0]),
    .rst_val(1'h1),
    .q_out(gnt0_n_s)
  );

  // strap caught on the first clock after reset release
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_cap_q <= 1'b0;
      strap_q <= 1'b0;
    end else if (!strap_cap_q) begin
      strap_cap_q <= 1'b1;
      strap_q <= arbiter_enable_strap;
    end
  end

  // configuration registered; resets to all enabled, all high
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_q <= pba_pkg::RST_ENABLE;
      high_q <= pba_pkg::RST_HIGH;
    end else begin
      enable_q <= cfg_req_enable;
      high_q <= cfg_req_high;
    end
  end

  // raw requests; bit 0 internal, 1..4 from pins 0..3 when arbiter on
  wire logic [4:0] raw_req = {~req_n_s, core_req};
  wire logic [4:0] live_req = raw_req & enable_q;
  wire logic [4:0] live_high = live_req & high_q;
  wire logic [4:0] live_low = live_req & ~high_q;
  wire logic gnt_busy = |(gnt_q & raw_req) && !bus_idle;

  pba_rr #(.N(5)) u_hrr (
    .req(hsnap_q),
    .last(hlast_q),
    .pick(hpick)
  );
  pba_rr #(.N(5)) u_lrr (
    .req(lsnap_q),
    .last(llast_q),
    .pick(lpick)
  );

  // snapshot arbitration with low group as one high slot
  always_comb begin
    state_d = state_q;
    hsnap_d = hsnap_q & live_high;
    lsnap_d = lsnap_q & live_low;
    hlast_d = hlast_q;
    llast_d = llast_q;
    low_slot_d = low_slot_q;
    gnt_d = gnt_q;
    if (hsnap_d == 5'h00) begin
      hsnap_d = live_high;
    end
    if (lsnap_d == 5'h00) begin
      lsnap_d = live_low;
    end
    if (!gnt_busy && (live_req != 5'h00)) begin
      if ((hpick & hsnap_d) != 5'h00 && !(low_slot_q && lpick != 5'h00)) begin
        gnt_d = hpick;
        hsnap_d = hsnap_d & ~hpick;
        hlast_d = hpick;
        state_d = pba_pkg::PBA_ST_HIGH;
        // high pass ended: give the low group its slot
        low_slot_d = (hsnap_d == 5'h00) || (hsnap_q == 5'h00);
      end else if ((lpick & lsnap_d) != 5'h00) begin
        gnt_d = lpick;
        lsnap_d = lsnap_d & ~lpick;
        llast_d = lpick;
        low_slot_d = 1'b0;
        hsnap_d = live_high;
        state_d = pba_pkg::PBA_ST_LOW;
      end else if (hsnap_d != 5'h00) begin
        low_slot_d = 1'b0;
        state_d = pba_pkg::PBA_ST_IDLE;
      end
    end else if (live_req == 5'h00) begin
      state_d = pba_pkg::PBA_ST_IDLE;
    end
  end

  // state registers; park on internal requester at reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= pba_pkg::PBA_ST_IDLE;
      hsnap_q <= 5'h00;
      lsnap_q <= 5'h00;
      hlast_q <= 5'h00;
      llast_q <= 5'h00;
      low_slot_q <= 1'b0;
      gnt_q <= pba_pkg::RST_GRANT;
    end else begin
      state_q <= state_d;
      hsnap_q <= hsnap_d;
      lsnap_q <= lsnap_d;
      hlast_q <= hlast_d;
      llast_q <= llast_d;
      low_slot_q <= low_slot_d;
      gnt_q <= gnt_d;
    end
  end

  // pin drive depends on strap
  assign ext_gnt_n_out = strap_q ? ~gnt_q[4:1] : 4'hF;
  assign ext_gnt_n_oe = strap_q ? 4'hF : 4'h0;
  assign ext_req_n_out = {3'h7, ~core_req};
  assign ext_req_n_oe = {3'h0, ~strap_q};
  assign core_gnt = strap_q ? gnt_q[0] : ~gnt0_n_s;
  assign grant_vec = strap_q ? gnt_q : 5'h00;
endmodule

/* File: rtl/pba_pkg.sv */
// What this block does
// - five requesters: four external masters and the internal core
// - with strap active, device drives external grants and internal grant
// - internal core grant is internal arbiter grant or grant pin, by strap
// - request 0 pin driven only when disabled; grant 0 pin is then input
// - request pins 3..1 output enables tied to zero
// - each requester can be enabled and placed high or low by configuration
// - after reset every requester sits in the high group
// - two priority levels, round-robin inside each level
// - low group is one slot in the high rotation
// - snapshot per level, served until empty, then retaken
// - after a low grant, resample so pending high masters go first
// - out of reset with no requests, park on the internal requester
// - when idle, keep the grant parked on the last served requester
package pba_pkg;
  localparam int unsigned NUM_REQ = 5;
  localparam int unsigned INT_IDX = 0;
  localparam logic [4:0] RST_ENABLE = 5'h1F;
  localparam logic [4:0] RST_HIGH = 5'h1F;
  localparam logic [4:0] RST_GRANT = 5'h01;
  localparam logic [2:0] SYNC_STAGES = 3'h3;
  typedef enum logic [2:0] {
    PBA_ST_IDLE = 3'b001,
    PBA_ST_HIGH = 3'b010,
    PBA_ST_LOW = 3'b100
  } pba_state_type;
endpackage

/* File: rtl/pba_rr.sv */
`timescale 1ns/1ns
// round-robin pick: first set bit after the last pointer
module pba_rr #(
  parameter int N = 5
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] last,
  output logic [N-1:0] pick
);
  logic [2*N-1:0] dbl;
  logic [2*N-1:0] mask;
  logic [N-1:0] res;
  // search from just above the last one-hot position, wrapping
  always_comb begin
    dbl = {req, req};
    mask = '0;
    res = '0;
    for (int i = 0; i < N; i++) begin
      if (last[i]) begin
        for (int j = 1; j <= N; j++) begin
          mask[i+j] = 1'b1;
        end
      end
    end
    if (last == '0) begin
      for (int j = 0; j < N; j++) begin
        mask[j] = 1'b1;
      end
    end
    for (int k = 2*N-1; k >= 0; k--) begin
      if (dbl[k] && mask[k]) begin
        res = '0;
        res[k % N] = 1'b1;
      end
    end
    pick = res;
  end
endmodule

/* File: rtl/pba_sync.sv */
`timescale 1ns/1ns
// three-stage synchroniser; a change counts once stages two and three agree
module pba_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] d_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  wire logic [W-1:0] agree = ~(s2_q ^ s3_q);
  // shift chain and agreement filter; stages rest at the idle level
  // so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_q <= rst_val;
      s2_q <= rst_val;
      s3_q <= rst_val;
      q_q <= rst_val;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= (agree & s3_q) | (~agree & q_q);
    end
  end
  assign q_out = q_q;
endmodule
